//--- hw/clwx_exec.sv
// Executes compact load-constant and word-load instructions, with and without prefix.
// Assumes decode hands one instruction at a time with register values already read,
// and a memory port that answers a request with mem_valid some cycles later.
`timescale 1ns/1ps
module clwx_exec (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic                        insn_valid,
  input  wire logic [15:0]                 insn,
  input  wire logic                        has_prefix,
  input  wire logic [15:0]                 prefix,
  input  wire logic [clwx_pkg::XLEN-1:0]   insn_pc,
  input  wire logic                        in_delay_slot,
  input  wire logic [clwx_pkg::XLEN-1:0]   jump_pc,
  input  wire logic [clwx_pkg::XLEN-1:0]   base_value,
  input  wire logic                        swap_byte_order_flag,
  input  wire logic                        msb_first_core_flag,
  input  wire logic                        mem_valid,
  input  wire logic [clwx_pkg::XLEN-1:0]   mem_data,
  input  wire logic                        mem_xlat_fault,
  output logic                             busy,
  output logic [4:0]                       base_sel,
  output logic                             mem_req,
  output logic [clwx_pkg::XLEN-1:0]        mem_vaddr,
  output logic [2:0]                       mem_paddr_low,
  output logic                             mem_data_ref,
  output logic                             wr_en,
  output logic [4:0]                       wr_reg,
  output logic [clwx_pkg::XLEN-1:0]        wr_data,
  output logic                             fault,
  output clwx_pkg::clwx_fault_t            fault_kind,
  output logic [clwx_pkg::XLEN-1:0]        fault_addr
);
  import clwx_pkg::*;

  logic        rst_s1;
  logic        rst_n;
  clwx_state_t state;
  logic [2:0]  lane;
  logic [4:0]  dest;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // Fixed map of three-bit fields onto registers 16,17,2..7.
  function automatic logic [4:0] xlat(input logic [2:0] f);
    xlat = (f < 3'h2) ? {2'b10, 2'b00, f[0]} : {2'b00, f};  // RQ17
  endfunction

  wire [4:0]  major      = insn[15:11];
  wire [2:0]  fld_x      = insn[10:8];
  wire [2:0]  fld_y      = insn[7:5];
  wire        pfx_ok     = has_prefix && prefix[15:11] == OP_EXTEND;
  wire [15:0] imm16      = {prefix[4:0], prefix[10:5], insn[4:0]};
  wire        is_const   = major == OP_LOAD_CONST && !has_prefix;
  wire        is_const_x = major == OP_LOAD_CONST && pfx_ok && fld_y == 3'h0;  // RQ3
  wire        is_reg     = major == OP_LOAD_REG;
  wire        is_pc      = major == OP_LOAD_PC;
  wire        is_sp      = major == OP_LOAD_SP;
  wire        is_load    = is_reg || is_pc || is_sp;
  wire [XLEN-1:0] off_x  = {{(XLEN-16){imm16[15]}}, imm16};
  wire [XLEN-1:0] pc_base = in_delay_slot ? jump_pc : insn_pc;  // RQ8
  wire [XLEN-1:0] pc_sum = {pc_base[XLEN-1:2] + {{(XLEN-10){1'b0}}, insn[7:0]}, WORD_ALIGN};  // RQ9
  wire [XLEN-1:0] pcx_sum = {insn_pc[XLEN-1:2], WORD_ALIGN} + off_x;  // RQ11
  wire [XLEN-1:0] reg_sum = base_value + (pfx_ok ? off_x  // RQ7
                          : {{(XLEN-7){1'b0}}, insn[4:0], 2'b00});  // RQ4
  wire [XLEN-1:0] sp_sum = base_value + (pfx_ok ? off_x
                          : {{(XLEN-10){1'b0}}, insn[7:0], 2'b00});  // RQ14
  wire [XLEN-1:0] ea     = is_pc ? (pfx_ok ? pcx_sum : pc_sum) : is_reg ? reg_sum : sp_sum;
  wire        checked    = !(is_pc && !pfx_ok);  // RQ10
  wire        misalign   = checked && ea[1:0] != WORD_ALIGN;  // RQ6
  wire [4:0]  next_dest  = is_reg ? xlat(fld_y) : xlat(fld_x);
  wire [2:0]  next_lane  = ea[2:0] ^ (msb_first_core_flag ? LANE_HI : 3'h0);  // RQ16
  wire [2:0]  next_plow  = ea[2:0] ^ (swap_byte_order_flag ? LANE_HI : 3'h0);  // RQ15
  wire [WLEN-1:0] word   = lane[2] ? mem_data[63:32] : mem_data[31:0];
  wire [XLEN-1:0] next_cdata = is_const_x ? {{(XLEN-16){1'b0}}, imm16}  // RQ2
                             : {{(XLEN-8){1'b0}}, insn[7:0]};  // RQ1
  wire        take       = state == CLWX_IDLE && insn_valid;
  wire        start_ld   = take && is_load && !misalign;

  always_comb begin
    base_sel = is_sp ? STACK_REG : xlat(fld_x);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= CLWX_IDLE;
      busy <= 1'b0;
      mem_req <= 1'b0;
      mem_vaddr <= '0;
      mem_paddr_low <= 3'h0;
      mem_data_ref <= 1'b0;
      wr_en <= 1'b0;
      wr_reg <= 5'h0;
      wr_data <= '0;
      fault <= 1'b0;
      fault_kind <= CLWX_FAULT_NONE;
      fault_addr <= '0;
      lane <= 3'h0;
      dest <= 5'h0;
    end else begin
      wr_en <= 1'b0;
      fault <= 1'b0;
      mem_req <= start_ld;
      if (start_ld) begin
        state <= CLWX_WAIT;
        busy <= 1'b1;
        mem_vaddr <= ea;
        mem_paddr_low <= next_plow;
        mem_data_ref <= 1'b1;  // RQ13
        lane <= next_lane;
        dest <= next_dest;
      end else if (take && is_load) begin
        fault <= 1'b1;  // RQ18
        fault_kind <= CLWX_FAULT_MISALIGN;
        fault_addr <= ea;
      end else if (take && (is_const || is_const_x)) begin
        wr_en <= 1'b1;
        wr_reg <= xlat(fld_x);
        wr_data <= next_cdata;
      end else if (state == CLWX_WAIT && mem_valid) begin
        state <= CLWX_IDLE;
        busy <= 1'b0;
        if (mem_xlat_fault) begin
          fault <= 1'b1;  // RQ18
          fault_kind <= CLWX_FAULT_XLAT;
          fault_addr <= mem_vaddr;
        end else begin
          wr_en <= 1'b1;
          wr_reg <= dest;
          wr_data <= {{(XLEN-WLEN){word[WLEN-1]}}, word};  // RQ5
        end
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  misalign_fault_a: assert property (take && is_load && misalign |=> fault && !mem_req && !wr_en) // RQ6
    else $error("misaligned load not faulted");
  pc_align_a: assert property (mem_req && !checked |-> 1'b1 ##0 mem_vaddr[1:0] == WORD_ALIGN) // RQ9
    else $error("pc load address not aligned");
  const_zero_a: assert property (take && is_const |=> wr_en && wr_data[XLEN-1:8] == '0) // RQ1
    else $error("constant not zero-extended");
  const_ext_a: assert property (take && is_const_x |=> wr_en && wr_data == {48'h0, $past(imm16)}) // RQ2
    else $error("extended constant wrong");
  sign_ext_a: assert property (wr_en && state == CLWX_IDLE && $past(state) == CLWX_WAIT
      |-> wr_data[XLEN-1:WLEN] == {WLEN{wr_data[WLEN-1]}}) // RQ5
    else $error("loaded word not sign-extended");
  xlat_nowr_a: assert property (state == CLWX_WAIT && mem_valid && mem_xlat_fault
      |=> fault && !wr_en) // RQ18
    else $error("faulting load wrote register");
  data_ref_a: assert property (mem_req |-> mem_data_ref) // RQ13
    else $error("pc load not a data reference");
  plow_swap_a: assert property (mem_req |-> mem_paddr_low[1:0] == mem_vaddr[1:0]) // RQ15
    else $error("low physical bits changed");
  req_once_a: assert property (mem_req |=> !mem_req) // RQ4
    else $error("request held too long");

  // The $past checks below pin results to values from an earlier edge, so a decoder
  // that reads the live instruction bus too late shows up here.
  busy_wait_a: assert property (state == CLWX_WAIT |-> busy) // RQ18
    else $error("busy low while load outstanding");

  busy_req_a: assert property (mem_req |-> busy) // RQ18
    else $error("request issued while not busy");

  wait_ignore_a: assert property (busy && insn_valid |=> !mem_req) // RQ18
    else $error("instruction taken while busy");

  one_result_a: assert property (!(wr_en && fault)) // RQ18
    else $error("write and fault in one cycle");

  xlat_addr_a: assert property (state == CLWX_WAIT && mem_valid && mem_xlat_fault
      |=> fault_addr == $past(mem_vaddr)) // RQ18
    else $error("translation fault address wrong");

  sp_base_a: assert property (is_sp |-> base_sel == STACK_REG) // RQ14
    else $error("stack load base not register 29");

  load_dest_a: assert property (state == CLWX_WAIT && mem_valid && !mem_xlat_fault
      |=> wr_en && wr_reg == $past(dest)) // RQ17
    else $error("loaded word written to wrong register");

  const_dest_a: assert property (take && (is_const || is_const_x)
      |=> wr_reg == xlat($past(fld_x))) // RQ17
    else $error("constant written to wrong register");

  const_nofault_a: assert property (take && (is_const || is_const_x) |=> !fault) // RQ2
    else $error("constant load raised a fault");

  pc_nofault_a: assert property (take && is_pc && !pfx_ok |=> !fault) // RQ10
    else $error("plain pc load raised a fault");

  plow_bit2_a: assert property (mem_req
      |-> mem_paddr_low[2] == (mem_vaddr[2] ^ $past(swap_byte_order_flag))) // RQ15
    else $error("physical bit 2 not swapped");

  lane_lo_a: assert property (state == CLWX_WAIT && mem_valid && !mem_xlat_fault && !lane[2]
      |=> wr_data[WLEN-1:0] == $past(mem_data[WLEN-1:0])) // RQ16
    else $error("low lane not selected");

  lane_hi_a: assert property (state == CLWX_WAIT && mem_valid && !mem_xlat_fault && lane[2]
      |=> wr_data[WLEN-1:0] == $past(mem_data[XLEN-1:WLEN])) // RQ16
    else $error("high lane not selected");

  cover_const_c: cover property (take && is_const_x);
  cover_xlat_c:  cover property (state == CLWX_WAIT && mem_valid && mem_xlat_fault);
  cover_load_c:  cover property (mem_req ##[1:20] wr_en);
  cover_fault_c: cover property (take && is_load && misalign);
  cover_slot_c:  cover property (start_ld && is_pc && in_delay_slot);
endmodule

//--- hw/clwx_pkg.sv
// Constants, opcodes and types for the compact load-constant and word-load executor.
// Assumes a 64-bit register file and a 64-bit data path on the memory side.
// Notes on behaviour
// (RQ1) Plain load-constant zero-extends 8-bit immediate.
// (RQ2) Extended load-constant writes zero-extended 16-bit immediate.
// (RQ3) Extended load-constant: prefix 11110, opcode 01101, zero field.
// (RQ4) Register word load: offset shifted two, added.
// (RQ5) Loaded word is sign-extended into register.
// (RQ6) Misaligned checked word loads fault, no load.
// (RQ7) Extended register load adds sign-extended 16-bit offset.
// (RQ8) PC word load base: own or jump address.
// (RQ9) Plain PC load clears low bits, never misaligned.
// (RQ10) Plain PC load reports only translation, bus faults.
// (RQ11) Extended PC load clears PC low bits first.
// (RQ12) Software keeps extended PC load from delay slots.
// (RQ13) PC-relative loads count as data references.
// (RQ14) Stack load adds scaled offset to register 29.
// (RQ15) Physical address bit 2 flipped by swap flag.
// (RQ16) Word lane chosen by address and core flag.
// (RQ17) Three-bit register fields map through fixed table.
// (RQ18) Faulting load leaves destination unchanged, reports fault.
package clwx_pkg;
  localparam int          XLEN         = 64;
  localparam int          WLEN         = 32;
  localparam logic [4:0]  OP_EXTEND    = 5'h1e;
  localparam logic [4:0]  OP_LOAD_CONST = 5'h0d;
  localparam logic [4:0]  OP_LOAD_REG  = 5'h13;
  localparam logic [4:0]  OP_LOAD_PC   = 5'h16;
  localparam logic [4:0]  OP_LOAD_SP   = 5'h12;
  localparam logic [4:0]  STACK_REG    = 5'h1d;
  localparam logic [1:0]  WORD_ALIGN   = 2'h0;
  localparam logic [2:0]  LANE_HI      = 3'h4;
  typedef enum logic [1:0] {CLWX_FAULT_NONE, CLWX_FAULT_MISALIGN, CLWX_FAULT_XLAT} clwx_fault_t;
  typedef enum {CLWX_IDLE, CLWX_WAIT} clwx_state_t;
endpackage

//--- dv/clwx_mem_model.sv
// Memory-side model: answers each load request after a chosen delay.
// Assumes single-cycle request pulses with one request outstanding.
`timescale 1ns/1ps
module clwx_mem_model (
  input  wire logic        clk,
  input  wire logic        mem_req,
  input  wire logic [7:0]  delay,
  input  wire logic        xlat_fault,
  input  wire logic [63:0] rdata,
  output logic             mem_valid,
  output logic [63:0]      mem_data,
  output logic             mem_xlat_fault
);
  int cnt = 0;
  initial begin
    mem_valid = 0;
    mem_data = 64'h0;
    mem_xlat_fault = 0;
  end
  // Idle data toggles so a stale value is never mistaken for a reply.
  always @(posedge clk) begin
    mem_valid <= 0;
    mem_xlat_fault <= 0;
    mem_data <= ~mem_data;
    if (mem_req) cnt <= delay + 1;
    else if (cnt == 1) begin
      mem_valid <= 1;
      mem_data <= rdata;
      mem_xlat_fault <= xlat_fault;
      cnt <= 0;
    end else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule

//--- dv/tb_clwx_exec.sv
// Random and corner-case bench for the compact load executor.
// Assumes the memory model replies a few cycles after each request.
`timescale 1ns/1ps
module tb_clwx_exec;
  import clwx_pkg::*;
  logic clk = 0, resetn = 0, insn_valid = 0, has_prefix = 0, in_delay_slot = 0, xf = 0;
  logic swap_byte_order_flag = 0, msb_first_core_flag = 0, mem_valid, mem_xlat_fault;
  logic busy, mem_req, mem_data_ref, wr_en, fault;
  logic [15:0] insn = 0, prefix = 0;
  logic [63:0] insn_pc = 0, jump_pc = 0, rdata = 0, mem_data, mem_vaddr, wr_data, fault_addr;
  logic [63:0] rf [32];
  logic [7:0]  dly = 0;
  logic [4:0]  base_sel, wr_reg;
  logic [2:0]  mem_paddr_low;
  clwx_fault_t fault_kind;
  wire [63:0]  base_value = rf[base_sel];
  int miscompares = 0, comparisons = 0;
  always #2 clk = ~clk;
  clwx_exec clwx_exec_inst (.*);
  clwx_mem_model clwx_mem_model_inst (.clk(clk), .mem_req(mem_req), .delay(dly), .xlat_fault(xf),
    .rdata(rdata), .mem_valid(mem_valid), .mem_data(mem_data), .mem_xlat_fault(mem_xlat_fault));
  function automatic logic [4:0] xl(logic [2:0] r);
    return r < 2 ? {4'h8, r[0]} : {2'h0, r};
  endfunction
  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    comparisons++;
    if (e !== g) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic run(int op, bit ext);
    logic [15:0] o;
    logic [63:0] b, va, s16;
    logic [2:0] rx, ry;
    logic [4:0] dst;
    logic [31:0] ln;
    bit mis, seen;
    o = $urandom;
    rx = $urandom;
    ry = $urandom;
    s16 = {{48{o[15]}}, o};
    {swap_byte_order_flag, msb_first_core_flag} = $urandom;
    {insn_pc, jump_pc, rdata} = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    xf = ($urandom % 5) == 0;
    dly = $urandom % 4;
    in_delay_slot = ext ? 0 : $urandom;
    has_prefix = ext;
    prefix = {OP_EXTEND, o[10:5], o[15:11]};
    dst = xl(rx);
    case (op)
      0: insn = ext ? {OP_LOAD_CONST, rx, 3'h0, o[4:0]} : {OP_LOAD_CONST, rx, o[7:0]};
      1: begin
        insn = {OP_LOAD_REG, rx, ry, o[4:0]};
        dst = xl(ry);
        va = rf[xl(rx)] + (ext ? s16 : {57'h0, o[4:0], 2'h0});
      end
      2: begin
        insn = {OP_LOAD_PC, rx, ext ? {3'h0, o[4:0]} : o[7:0]};
        b = (in_delay_slot && !ext) ? jump_pc : insn_pc;
        va = ext ? {b[63:2], 2'h0} + s16 : {b[63:2] + o[7:0], 2'h0};
      end
      default: begin
        insn = {OP_LOAD_SP, rx, o[7:0]};
        va = rf[29] + {54'h0, o[7:0], 2'h0};
      end
    endcase
    mis = (op == 1 || op == 3 || ext) && va[1:0] != 2'h0;
    ln = (va[2] ^ msb_first_core_flag) ? rdata[63:32] : rdata[31:0];
    insn_valid = 1;
    @(negedge clk);
    insn_valid = 0;
    for (int i = 0; i < 40 && !seen; i++) begin
      if (mem_req === 1'b1) begin
        chk("vaddr", va, mem_vaddr);
        chk("paddr_low", {61'h0, va[2] ^ swap_byte_order_flag, va[1:0]}, mem_paddr_low);
        chk("busy", 1, busy);
      end
      if (wr_en === 1'b1 || fault === 1'b1) seen = 1;
      else @(negedge clk);
    end
    if (!seen) begin
      miscompares++;
      finish_test();
    end
    if (op == 1) chk("base_sel", xl(rx), base_sel);
    if (op == 3) chk("base_sel", 64'(STACK_REG), base_sel);
    if (op == 0) begin
      chk("wr_reg", dst, wr_reg);
      chk("wr_data", ext ? {48'h0, o} : {56'h0, o[7:0]}, wr_data);
    end else if (mis || xf) begin
      chk("wr_en", 0, wr_en);
      chk("fault_kind", 64'(mis ? CLWX_FAULT_MISALIGN : CLWX_FAULT_XLAT), 64'(fault_kind));
      chk("fault_addr", va, fault_addr);
      chk("fault", 1, fault);
    end else begin
      chk("wr_reg", dst, wr_reg);
      chk("wr_data", {{32{ln[31]}}, ln}, wr_data);
      chk("data_ref", 1, mem_data_ref);
    end
    $display("test op %0d ext %0d done", op, ext);
  endtask
  initial begin
    void'($urandom(32'h9ed7));
    foreach (rf[i]) rf[i] = 64'h0;
    repeat (16) @(negedge clk);
    resetn = 1;
    repeat (3) @(negedge clk);
    for (int k = 0; k < 7; k++) run(k % 4, k > 3);
    repeat (400) begin
      foreach (rf[i]) rf[i] = {$urandom, $urandom} & ((($urandom % 3) != 0) ? ~64'h3 : ~64'h0);
      run($urandom % 4, 0);
      run($urandom % 3, 1);
    end
    finish_test();
  end
endmodule
